/* File: hdl/dsu_pkg.sv */
// Summary of operation
// - toggle pin falling edge copies input register A into code register.
// - toggle pin rising edge copies input register B into code register.
// - toggle updates touch only channels whose toggle select bit is one.
// - serial data is sampled into the shift register on each sck rise while chip select/load is low.
// - frames of 24, 32 or multiples of 32 bits are all accepted.
// - serial output is the 32-bit register end, changing on falling sck.
// - serial output is high impedance while chip select/load is high.
// - while chip select/load is low, sck shifts and serial output drives.
// - chip select/load rise stops shifting, disables output, runs command.
// - update falling edge with chip select high updates all channels.
// - update input is ignored while chip select/load is low.
// - open-drain fault output pulls low while a fault is flagged.
// - fault stays low until the next chip select/load rising edge.
// - clear low forces zero code and high impedance range on all channels.
// - clear also zeroes power, toggle select and monitor mux registers, not reference enable.
// - reference strap grounded at power-up starts with reference disabled.
// - disabled monitor mux puts the monitor output in high impedance.
// - frame is command nibble, address nibble, then 16-bit data msb first.
// - commands with an undefined channel address are ignored entirely.
// - any update powers the channel up and refreshes code and span.
package dsu_pkg;
  localparam int NUM_CH      = 5;
  localparam int DATA_W      = 16;
  localparam int SPAN_W      = 4;
  localparam int SHIFT_W     = 32;
  localparam int FAULT_W     = 4;
  localparam int CMD_POS     = 20;
  localparam int ADDR_POS    = 16;
  localparam int DATA_POS    = 0;
  localparam int MUX_SEL_W   = 5;
  localparam logic [3:0] CMD_WR_N      = 4'h0;
  localparam logic [3:0] CMD_WR_ALL    = 4'h8;
  localparam logic [3:0] CMD_SPAN_N    = 4'h6;
  localparam logic [3:0] CMD_SPAN_ALL  = 4'he;
  localparam logic [3:0] CMD_UPD_N     = 4'h1;
  localparam logic [3:0] CMD_UPD_ALL   = 4'h9;
  localparam logic [3:0] CMD_WRUPD_N   = 4'h3;
  localparam logic [3:0] CMD_WRN_UPDA  = 4'h2;
  localparam logic [3:0] CMD_WRA_UPDA  = 4'ha;
  localparam logic [3:0] CMD_PD_N      = 4'h4;
  localparam logic [3:0] CMD_PD_CHIP   = 4'h5;
  localparam logic [3:0] CMD_MON_MUX   = 4'hb;
  localparam logic [3:0] CMD_TOG_SEL   = 4'hc;
  localparam logic [3:0] CMD_TOG_GLB   = 4'hd;
  localparam logic [3:0] CMD_CONFIG    = 4'h7;
  localparam logic [3:0] CMD_NOP       = 4'hf;
  localparam logic [15:0] CODE_RST     = 16'h0000;
  localparam logic [3:0]  SPAN_HIZ     = 4'h0;
  localparam logic [3:0]  MAX_ADDR     = 4'h4;
  // config word bit that turns the internal reference off
  localparam int CFG_REF_OFF_BIT = 1;
  localparam int CFG_W           = 4;
  // clock_in edges before the strap synchroniser output is trustworthy
  localparam int STRAP_WAIT      = 3;
endpackage

/* File: hdl/dsu_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module dsu_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output var  logic q_out
);
  logic meta_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/dsu_link.sv */
`timescale 1ns/100ps
`default_nettype none
// link side: shift register on sck, frame captured at load rise
module dsu_link (
  // serial pins
  input  wire logic        sck_in,
  input  wire logic        cs_load_n_in,
  input  wire logic        sdi_in,
  output var  logic        sdo_out,
  output var  logic        sdo_oe_out,
  // frame toward core, cleared by system reset only
  input  wire logic        rst_in,
  output var  logic [23:0] frame_out,
  output var  logic        frame_tgl_out,
  input  wire logic [7:0]  echo_in
);
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  // cs high only disables shifting on sck rise; shift register keeps data
  always_comb begin
    shift_nxt = {shift_r[30:0], sdi_in};
  end
  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= 32'h0;
    end else if (!cs_load_n_in) begin
      shift_r <= shift_nxt;
    end
  end
  always_ff @(negedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      sdo_out <= 1'b0;
    end else begin
      sdo_out <= shift_r[31];
    end
  end
  assign sdo_oe_out = ~cs_load_n_in;
  // low 24 bits are the command word, leading bits of longer frames drop out
  always_ff @(posedge cs_load_n_in or posedge rst_in) begin
    if (rst_in) begin
      frame_out     <= 24'h0;
      frame_tgl_out <= 1'b0;
    end else begin
      frame_out     <= shift_r[23:0];
      frame_tgl_out <= ~frame_tgl_out;
    end
  end
  logic unused_echo;
  assign unused_echo = ^echo_in;
endmodule
`default_nettype wire

/* File: hdl/dsu_core.sv */
`timescale 1ns/100ps
`default_nettype none
module dsu_core #(
  parameter int NUM_CH  = dsu_pkg::NUM_CH,
  parameter int FAULT_W = dsu_pkg::FAULT_W
) (
  // system
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  // serial link
  input  wire logic                  sck_in,
  input  wire logic                  chip_select_load_n,
  input  wire logic                  sdi_in,
  output var  logic                  sdo_out,
  output var  logic                  sdo_oe_out,
  // asynchronous pins
  input  wire logic                  async_toggle_pin,
  input  wire logic                  async_update_n,
  input  wire logic                  async_clear_n,
  input  wire logic                  reference_comp_strap,
  input  wire logic [FAULT_W-1:0]    fault_src_in,
  // fault open drain, low-active
  output logic                       fault_n_out,
  output logic                       fault_n_oe_out,
  // channel state
  output logic [NUM_CH*16-1:0]       dac_code_out,
  output logic [NUM_CH*4-1:0]        dac_span_out,
  output logic [NUM_CH-1:0]          ch_powered_out,
  output logic [NUM_CH-1:0]          toggle_sel_out,
  output logic                       ref_enable_out,
  output logic [4:0]                 mux_sel_out,
  output logic                       mux_oe_out
);
  // ---------------- link domain ----------------
  logic [23:0] frame_w;
  logic        frame_tgl_w;
  logic        sdo_w;
  logic        sdo_oe_w;
  dsu_link u_link (
    .sck_in        (sck_in),
    .cs_load_n_in  (chip_select_load_n),
    .sdi_in        (sdi_in),
    .sdo_out       (sdo_w),
    .sdo_oe_out    (sdo_oe_w),
    .rst_in        (reset_in),
    .frame_out     (frame_w),
    .frame_tgl_out (frame_tgl_w),
    .echo_in       (8'h00)
  );
  assign sdo_out    = sdo_w;
  assign sdo_oe_out = sdo_oe_w;

  // ---------------- synchronisers ----------------
  logic tgl_s;
  logic tgp_s;
  logic upd_n_s;
  logic clr_n_s;
  logic cs_s;
  logic strap_s;
  logic [FAULT_W-1:0] flt_s;
  dsu_sync #(.RST_VAL(1'b0)) u_s_tgl (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(frame_tgl_w), .q_out(tgl_s));
  dsu_sync #(.RST_VAL(1'b0)) u_s_tgp (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(async_toggle_pin), .q_out(tgp_s));
  dsu_sync #(.RST_VAL(1'b1)) u_s_upd (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(async_update_n), .q_out(upd_n_s));
  dsu_sync #(.RST_VAL(1'b1)) u_s_clr (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(async_clear_n), .q_out(clr_n_s));
  dsu_sync #(.RST_VAL(1'b1)) u_s_cs (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(chip_select_load_n), .q_out(cs_s));
  dsu_sync #(.RST_VAL(1'b1)) u_s_strap (.clk_in(clock_in), .rst_in(reset_in),
    .d_in(reference_comp_strap), .q_out(strap_s));
  genvar gi;
  generate
    for (gi = 0; gi < FAULT_W; gi++) begin : g_flt
      dsu_sync #(.RST_VAL(1'b0)) u_s_flt (.clk_in(clock_in), .rst_in(reset_in),
        .d_in(fault_src_in[gi]), .q_out(flt_s[gi]));
    end
  endgenerate

  // ---------------- edge detect state ----------------
  logic tgl_d_r, tgl_d_nxt;
  logic tgp_d_r, tgp_d_nxt;
  logic upd_d_r, upd_d_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic frame_ev, tgp_rise, tgp_fall, upd_fall;
  always_comb begin
    tgl_d_nxt      = tgl_s;
    tgp_d_nxt      = tgp_s;
    upd_d_nxt      = upd_n_s;
    strap_cnt_nxt  = strap_cnt_r;
    // strap is a static pin, so it is followed only until its synchroniser has filled, then held
    if (strap_cnt_r != 2'(dsu_pkg::STRAP_WAIT)) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
    end
  end
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      tgl_d_r      <= 1'b0;
      tgp_d_r      <= 1'b0;
      upd_d_r      <= 1'b1;
      strap_cnt_r  <= 2'h0;
    end else begin
      tgl_d_r      <= tgl_d_nxt;
      tgp_d_r      <= tgp_d_nxt;
      upd_d_r      <= upd_d_nxt;
      strap_cnt_r  <= strap_cnt_nxt;
    end
  end
  assign frame_ev = tgl_s ^ tgl_d_r;
  assign tgp_rise = tgp_s & ~tgp_d_r;
  assign tgp_fall = ~tgp_s & tgp_d_r;
  // update pin only counts while load line is high
  assign upd_fall = ~upd_n_s & upd_d_r & cs_s;

  // ---------------- channel registers ----------------
  logic [15:0] in_a_r   [NUM_CH];
  logic [15:0] in_a_nxt [NUM_CH];
  logic [15:0] in_b_r   [NUM_CH];
  logic [15:0] in_b_nxt [NUM_CH];
  logic [3:0]  in_s_r   [NUM_CH];
  logic [3:0]  in_s_nxt [NUM_CH];
  logic [15:0] code_r   [NUM_CH];
  logic [15:0] code_nxt [NUM_CH];
  logic [3:0]  span_r   [NUM_CH];
  logic [3:0]  span_nxt [NUM_CH];
  logic [NUM_CH-1:0] pwr_r, pwr_nxt;
  logic [NUM_CH-1:0] tsel_r, tsel_nxt;
  logic [4:0] mux_r, mux_nxt;
  logic       mux_en_r, mux_en_nxt;
  logic       ref_en_r, ref_en_nxt;
  logic       fault_r, fault_nxt;
  logic [3:0] cmd, addr;
  logic [15:0] data;
  logic        addr_ok;
  logic [NUM_CH-1:0] sel_n, wr_a, upd, use_b;
  assign cmd     = frame_w[dsu_pkg::CMD_POS +: 4];
  assign addr    = frame_w[dsu_pkg::ADDR_POS +: 4];
  assign data    = frame_w[dsu_pkg::DATA_POS +: 16];
  assign addr_ok = (addr <= dsu_pkg::MAX_ADDR);

  always_comb begin
    sel_n      = '0;
    wr_a       = '0;
    upd        = '0;
    use_b      = '0;
    tsel_nxt   = tsel_r;
    mux_nxt    = mux_r;
    mux_en_nxt = mux_en_r;
    ref_en_nxt = ref_en_r;
    pwr_nxt    = pwr_r;
    for (int i = 0; i < NUM_CH; i++) begin
      in_a_nxt[i] = in_a_r[i];
      in_b_nxt[i] = in_b_r[i];
      in_s_nxt[i] = in_s_r[i];
      code_nxt[i] = code_r[i];
      span_nxt[i] = span_r[i];
      sel_n[i]    = addr_ok && (addr == 4'(i));
    end
    if (frame_ev && addr_ok) begin
      case (cmd)
        dsu_pkg::CMD_WR_N:     wr_a = sel_n;
        dsu_pkg::CMD_WR_ALL:   wr_a = '1;
        dsu_pkg::CMD_UPD_N:    upd  = sel_n;
        dsu_pkg::CMD_UPD_ALL:  upd  = '1;
        dsu_pkg::CMD_WRUPD_N: begin
          wr_a = sel_n;
          upd  = sel_n;
        end
        dsu_pkg::CMD_WRN_UPDA: begin
          wr_a = sel_n;
          upd  = '1;
        end
        dsu_pkg::CMD_WRA_UPDA: begin
          wr_a = '1;
          upd  = '1;
        end
        dsu_pkg::CMD_SPAN_N, dsu_pkg::CMD_SPAN_ALL: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (cmd == dsu_pkg::CMD_SPAN_ALL || sel_n[i]) begin
              in_s_nxt[i] = data[3:0];
            end
          end
        end
        dsu_pkg::CMD_PD_N:     pwr_nxt = pwr_r & ~sel_n;
        dsu_pkg::CMD_PD_CHIP:  pwr_nxt = '0;
        dsu_pkg::CMD_MON_MUX: begin
          mux_nxt    = data[4:0];
          mux_en_nxt = (data[4:0] != 5'h00);
        end
        dsu_pkg::CMD_TOG_SEL:  tsel_nxt = data[NUM_CH-1:0];
        dsu_pkg::CMD_TOG_GLB: begin
          // software toggle: data bit picks register b
          upd  = tsel_r;
          use_b = data[0] ? tsel_r : '0;
        end
        dsu_pkg::CMD_CONFIG:   ref_en_nxt = ~data[dsu_pkg::CFG_REF_OFF_BIT];
        default: ;
      endcase
    end
    if (upd_fall) begin
      upd = '1;
    end
    if (tgp_fall) begin
      upd   = upd | tsel_r;
      use_b = use_b & ~tsel_r;
    end
    if (tgp_rise) begin
      upd   = upd | tsel_r;
      use_b = use_b | tsel_r;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (wr_a[i]) begin
        in_a_nxt[i] = data;
      end
      if (upd[i]) begin
        code_nxt[i] = use_b[i] ? in_b_nxt[i] : in_a_nxt[i];
        span_nxt[i] = in_s_nxt[i];
        pwr_nxt[i]  = 1'b1;
      end
    end
    if (strap_cnt_r != 2'(dsu_pkg::STRAP_WAIT)) begin
      ref_en_nxt = strap_s;
    end
    // new fault wins over the load-line clear in the same cycle
    fault_nxt = (fault_r & ~frame_ev) | (|flt_s);
    if (!clr_n_s) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_a_nxt[i] = dsu_pkg::CODE_RST;
        in_b_nxt[i] = dsu_pkg::CODE_RST;
        in_s_nxt[i] = dsu_pkg::SPAN_HIZ;
        code_nxt[i] = dsu_pkg::CODE_RST;
        span_nxt[i] = dsu_pkg::SPAN_HIZ;
      end
      pwr_nxt    = '0;
      tsel_nxt   = '0;
      mux_nxt    = '0;
      mux_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_a_r[i] <= dsu_pkg::CODE_RST;
        in_b_r[i] <= dsu_pkg::CODE_RST;
        in_s_r[i] <= dsu_pkg::SPAN_HIZ;
        code_r[i] <= dsu_pkg::CODE_RST;
        span_r[i] <= dsu_pkg::SPAN_HIZ;
      end
      pwr_r    <= '0;
      tsel_r   <= '0;
      mux_r    <= '0;
      mux_en_r <= 1'b0;
      ref_en_r <= 1'b1;
      fault_r  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        in_a_r[i] <= in_a_nxt[i];
        in_b_r[i] <= in_b_nxt[i];
        in_s_r[i] <= in_s_nxt[i];
        code_r[i] <= code_nxt[i];
        span_r[i] <= span_nxt[i];
      end
      pwr_r    <= pwr_nxt;
      tsel_r   <= tsel_nxt;
      mux_r    <= mux_nxt;
      mux_en_r <= mux_en_nxt;
      ref_en_r <= ref_en_nxt;
      fault_r  <= fault_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      dac_code_out[i*16 +: 16] = code_r[i];
      dac_span_out[i*4 +: 4]   = span_r[i];
    end
  end
  assign ch_powered_out = pwr_r;
  assign toggle_sel_out = tsel_r;
  assign ref_enable_out = ref_en_r;
  assign mux_sel_out    = mux_r;
  assign mux_oe_out     = mux_en_r;
  assign fault_n_out    = 1'b0;
  assign fault_n_oe_out = fault_r;

  a_fault_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    fault_r && !frame_ev |=> fault_r) else $error("fault released early");
  a_fault_set: assert property (@(posedge clock_in) disable iff (reset_in)
    (|flt_s) |=> fault_r) else $error("fault source not flagged");
  a_toggle_sel: assert property (@(posedge clock_in) disable iff (reset_in)
    tgp_rise && !upd_fall && !frame_ev && clr_n_s && !tsel_r[1] |=> $stable(code_r[1]))
    else $error("unselected channel toggled");
  a_toggle_fall: assert property (@(posedge clock_in) disable iff (reset_in)
    tgp_fall && !upd_fall && !frame_ev && clr_n_s && tsel_r[0]
    |=> code_r[0] == $past(in_a_r[0])) else $error("toggle fall missed register a");
  a_update_gate: assert property (@(posedge clock_in) disable iff (reset_in)
    !cs_s && !frame_ev && !tgp_rise && !tgp_fall && clr_n_s |=> $stable(dac_code_out))
    else $error("code changed while load line low");
  a_clear_zero: assert property (@(posedge clock_in) disable iff (reset_in)
    !clr_n_s |=> (tsel_r == '0) && (code_r[0] == 16'h0000))
    else $error("clear did not zero");
  a_sdo_hiz: assert property (@(posedge clock_in) disable iff (reset_in)
    chip_select_load_n |-> !sdo_oe_out) else $error("sdo driven while deselected");
endmodule
`default_nettype wire

/* File: verif/dsu_spi_master.sv */
`timescale 1ns/100ps
`default_nettype none
module dsu_spi_master (
  // serial pins
  output var  logic sck_out,
  output var  logic cs_n_out,
  output var  logic sdi_out,
  input  wire logic sdo_in
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end
  // sends bits[n-1:0] msb first; sck idles low and runs only inside a frame
  task automatic xfer(input logic [63:0] bits, input int n, output logic [63:0] echo);
    echo     = '0;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = bits[i];
      #7.5;
      sck_out = 1'b1;
      echo[i] = sdo_in;
      #7.5;
      sck_out = 1'b0;
    end
    #7.5;
    cs_n_out = 1'b1;
    // a deselected data line carries nothing useful, so do not leave the last bit on it
    sdi_out  = ~sdi_out;
  endtask
endmodule
`default_nettype wire

/* File: verif/dsu_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module dsu_core_tb;
  logic             clock_in;
  logic             reset_in;
  logic             tgl;
  logic             upd_n;
  logic             clr_n;
  logic             strap;
  logic [3:0]       fault_src;
  logic [63:0]      echo;
  wire logic        sck;
  wire logic        cs_n;
  wire logic        sdi;
  wire logic        sdo;
  wire logic        sdo_oe;
  wire logic        sdo_line;
  wire logic        flt_n;
  wire logic        flt_oe;
  wire logic        ref_en;
  wire logic        mux_oe;
  wire logic [79:0] code;
  wire logic [19:0] span;
  wire logic [4:0]  pwr;
  wire logic [4:0]  tsel;
  wire logic [4:0]  mux_sel;
  int               failures;
  int               checks;
  localparam logic [63:0] DZ = 64'h3cf0_5a5a_c3a0_1357;

  assign sdo_line = sdo_oe ? sdo : 1'bz;

  dsu_core i_dut (
    .clock_in(clock_in), .reset_in(reset_in), .sck_in(sck), .chip_select_load_n(cs_n),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .async_toggle_pin(tgl),
    .async_update_n(upd_n), .async_clear_n(clr_n), .reference_comp_strap(strap),
    .fault_src_in(fault_src), .fault_n_out(flt_n), .fault_n_oe_out(flt_oe),
    .dac_code_out(code), .dac_span_out(span), .ch_powered_out(pwr),
    .toggle_sel_out(tsel), .ref_enable_out(ref_en), .mux_sel_out(mux_sel),
    .mux_oe_out(mux_oe)
  );

  dsu_spi_master i_spi (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // one command frame, then enough idle time for the core to act on it
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                      input int n);
    logic [63:0] e;
    i_spi.xfer({32'h0, 8'ha5, c, a, d}, n, e);
    cyc(8);
  endtask

  initial begin
    #2ms;
    failures++;
    print_verdict();
  end

  initial begin
    reset_in  = 1'b1;
    tgl       = 1'b0;
    upd_n     = 1'b1;
    clr_n     = 1'b1;
    strap     = 1'b0;
    fault_src = 4'h0;
    failures  = 0;
    checks    = 0;
    cyc(20);
    reset_in <= 1'b0;
    cyc(8);
    check(ref_en, 1'b0);
    check(sdo_oe, 1'b0);
    send(4'h0, 4'h2, 16'hbeef, 24);
    check(code, 80'h0);
    send(4'h1, 4'h2, 16'h0000, 32);
    check(code, {32'h0, 16'hbeef, 32'h0});
    check(pwr, 5'b00100);
    send(4'ha, 4'h5, 16'h1234, 24);
    check(code, {32'h0, 16'hbeef, 32'h0});
    // two chained words in one frame: only the last word runs
    i_spi.xfer(DZ, 64, echo);
    cyc(8);
    check(echo[31:0], DZ[63:32]);
    check(code, {5{16'h1357}});
    check({sdo_oe, pwr}, 6'h1f);
    send(4'he, 4'h0, 16'h0003, 32);
    send(4'h9, 4'h0, 16'h0000, 24);
    check(span, {5{4'h3}});
    send(4'h0, 4'h1, 16'h0aa0, 24);
    fork
      i_spi.xfer({40'h0, 4'hf, 4'h0, 16'h0}, 32, echo);
      begin
        cyc(2);
        check(sdo_oe, 1'b1);
        upd_n <= 1'b0;
        cyc(4);
        upd_n <= 1'b1;
      end
    join
    cyc(8);
    check(code, {5{16'h1357}});
    upd_n <= 1'b0;
    cyc(4);
    upd_n <= 1'b1;
    cyc(8);
    check(code, {48'h1357_1357_1357, 16'h0aa0, 16'h1357});
    send(4'hc, 4'h0, 16'h0005, 24);
    check(tsel, 5'b00101);
    tgl <= 1'b1;
    cyc(30);
    check(code, {32'h1357_1357, 16'h0, 16'h0aa0, 16'h0});
    send(4'h0, 4'h0, 16'h2222, 24);
    tgl <= 1'b0;
    cyc(30);
    check(code, {48'h1357_1357_1357, 16'h0aa0, 16'h2222});
    send(4'hb, 4'h0, 16'h0000, 24);
    check(mux_oe, 1'b0);
    send(4'hb, 4'h0, 16'h0003, 24);
    check({mux_oe, mux_sel}, 6'h23);
    // a one-cycle fault must still be caught and held
    fault_src <= 4'h4;
    cyc(1);
    fault_src <= 4'h0;
    for (int i = 0; i < 10 && flt_oe !== 1'b1; i++) cyc(1);
    if (flt_oe !== 1'b1) begin
      failures++;
      print_verdict();
    end
    cyc(10);
    check({flt_oe, flt_n}, 2'b10);
    send(4'hf, 4'h0, 16'h0000, 24);
    check(flt_oe, 1'b0);
    send(4'h4, 4'h1, 16'h0000, 24);
    check(pwr, 5'b11101);
    send(4'h3, 4'h1, 16'h0444, 24);
    check({pwr, code[31:16]}, {5'h1f, 16'h0444});
    send(4'h6, 4'h3, 16'h0005, 24);
    send(4'h2, 4'h4, 16'h0777, 24);
    check({span[15:12], code[79:64]}, {4'h5, 16'h0777});
    send(4'h5, 4'h0, 16'h0000, 24);
    send(4'h8, 4'h0, 16'h0888, 24);
    send(4'hd, 4'h0, 16'h0001, 24);
    check({pwr, code[47:0]}, {5'b00101, 16'h0, 16'h0444, 16'h0});
    send(4'h9, 4'h0, 16'h0000, 24);
    check(code, {5{16'h0888}});
    send(4'h7, 4'h0, 16'h0000, 24);
    check(ref_en, 1'b1);
    clr_n <= 1'b0;
    cyc(6);
    check(code, 80'h0);
    check({span, tsel, pwr, mux_oe}, 31'h0);
    clr_n <= 1'b1;
    cyc(6);
    print_verdict();
  end
endmodule
`default_nettype wire
